// ==== shared/cfbu_consts.vh ====
// Purpose: Constants for the conditional flag branch unit
// Assumes: 16-bit word program counter, 7-bit relative offset
// Notes: Opcode selects are a local 3-bit code from the decoder
`ifndef CFBU_CONSTS_VH
`define CFBU_CONSTS_VH
`define CFBU_PC_W 16
`define CFBU_OFS_W 7
`define CFBU_SEL_W 3
`define CFBU_SEL_NEG 3'h0
`define CFBU_SEL_POS 3'h1
`define CFBU_SEL_GE 3'h2
`define CFBU_SEL_LT 3'h3
`define CFBU_SEL_HS 3'h4
`define CFBU_SEL_HC 3'h5
`define CFBU_SEL_TS 3'h6
`define CFBU_SEL_TC 3'h7
`define CFBU_PC_RST 16'h0000
`endif

// ==== logic/cfbu_cond_eval.v ====
// Purpose: Condition evaluation for the flag branches
// Assumes: Flags are stable while a branch is decoded
// Notes: Purely combinational; read-only on the flags
`default_nettype none
`include "cfbu_consts.vh"
module cfbu_cond_eval (
  // Selection and flags
  input wire [`CFBU_SEL_W-1:0] sel_i,
  input wire neg_i,
  input wire ovf_i,
  input wire half_i,
  input wire xfer_i,
  // Result
  output reg take_o
);
  wire sign_w;
  assign sign_w = neg_i ^ ovf_i;
  always @*
  begin
    take_o = 1'b0;
    case (sel_i)
      `CFBU_SEL_NEG: take_o = neg_i;
      `CFBU_SEL_POS: take_o = ~neg_i;
      `CFBU_SEL_GE: take_o = ~sign_w;
      `CFBU_SEL_LT: take_o = sign_w;
      `CFBU_SEL_HS: take_o = half_i;
      `CFBU_SEL_HC: take_o = ~half_i;
      `CFBU_SEL_TS: take_o = xfer_i;
      `CFBU_SEL_TC: take_o = ~xfer_i;
      default: take_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ==== logic/cfbu_branch_unit.v ====
// Purpose: Resolve conditional relative branches on N, V, H, T flags
// Assumes: branch_valid_i is a one-cycle pulse with pc_i of the branch word
// Notes: Taken branches occupy a second cycle; busy_o stalls the fetch
`default_nettype none
`include "cfbu_consts.vh"
// Function
// - Branch-on-negative jumps to PC plus offset plus one when N is 1.
// - Branch-on-positive jumps to PC plus offset plus one when N is 0.
// - Signed greater-or-equal jumps when N xor V is 0.
// - Signed less-than jumps when N xor V is 1.
// - Half-carry-set branch jumps when H is 1.
// - Half-carry-clear branch jumps when H is 0.
// - Transfer-set branch jumps when T is 1.
// - Transfer-clear branch jumps when T is 0.
// - No branch changes any status flag, taken or not.
module cfbu_branch_unit (
  // Clock and reset
  input wire ref_clk_i,
  input wire sys_rst_i,
  // Decoded branch
  input wire branch_valid_i,
  input wire [`CFBU_SEL_W-1:0] branch_sel_i,
  input wire [`CFBU_OFS_W-1:0] branch_ofs_i,
  input wire [`CFBU_PC_W-1:0] pc_i,
  // Status flags
  input wire flag_neg_i,
  input wire flag_ovf_i,
  input wire flag_half_i,
  input wire flag_xfer_i,
  // Result
  output reg pc_load_o,
  output reg [`CFBU_PC_W-1:0] pc_target_o,
  output reg busy_o,
  output reg done_o,
  output reg taken_o
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_TAKEN = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;

  // ----------------------------------------
  // Internal signals
  // ----------------------------------------
  wire take_w;
  wire accept_w;
  wire [`CFBU_PC_W-1:0] fall_pc_w;
  wire [`CFBU_PC_W-1:0] jump_pc_w;
  reg pc_load_next;
  reg [`CFBU_PC_W-1:0] pc_target_next;
  reg busy_next;
  reg done_next;
  reg taken_next;

  // Port timing, in rising edges after the edge that takes a request:
  //   not taken: +1 done_o, with the next word on pc_target_o
  //   taken: +1 pc_load_o and busy_o with the target, +2 done_o and taken_o
  //   a request at +1 of a taken branch is dropped, never queued

  // ----------------------------------------
  // Address arithmetic
  // ----------------------------------------
  // Offset is two's complement: widen by copying its sign bit
  function [`CFBU_PC_W-1:0] sext_ofs;
    input [`CFBU_OFS_W-1:0] ofs;
    begin
      sext_ofs = {{(`CFBU_PC_W-`CFBU_OFS_W){ofs[`CFBU_OFS_W-1]}}, ofs};
    end
  endfunction

  // Wraps at the top of program memory, as the fetch counter does
  function [`CFBU_PC_W-1:0] next_word;
    input [`CFBU_PC_W-1:0] pc;
    begin
      next_word = pc + 16'h0001;
    end
  endfunction

  // Taken target is the fall-through word moved by the offset
  function [`CFBU_PC_W-1:0] rel_target;
    input [`CFBU_PC_W-1:0] pc;
    input [`CFBU_OFS_W-1:0] ofs;
    begin
      rel_target = next_word(pc) + sext_ofs(ofs);
    end
  endfunction

  // Flags are inputs only: nothing here can write them
  cfbu_cond_eval u_eval (
    .sel_i(branch_sel_i),
    .neg_i(flag_neg_i),
    .ovf_i(flag_ovf_i),
    .half_i(flag_half_i),
    .xfer_i(flag_xfer_i),
    .take_o(take_w)
  );

  // ----------------------------------------
  // Request acceptance
  // ----------------------------------------
  // A request in the stall cycle of a taken branch is dropped
  assign accept_w = branch_valid_i && (state_reg == ST_IDLE);
  // Selection and offset only matter on an accepted edge
  assign fall_pc_w = next_word(pc_i);
  assign jump_pc_w = rel_target(pc_i, branch_ofs_i);

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (accept_w && take_w)
        begin
          state_next = ST_TAKEN;
        end
        else
        begin
          state_next = ST_IDLE;
        end
      end
      ST_TAKEN:
      begin
        state_next = ST_IDLE;
      end
      default:
      begin
        // Stray codes fall back to idle
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Target address
  // ----------------------------------------
  // Holds between branches so a late reader still sees the last target
  always @*
  begin
    pc_target_next = pc_target_o;
    if (accept_w)
    begin
      if (take_w)
      begin
        pc_target_next = jump_pc_w;
      end
      else
      begin
        // Not taken: report the next word for the fetch
        pc_target_next = fall_pc_w;
      end
    end
  end

  // ----------------------------------------
  // Pulse outputs
  // ----------------------------------------
  always @*
  begin
    pc_load_next = 1'b0;
    busy_next = 1'b0;
    done_next = 1'b0;
    taken_next = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        if (accept_w && take_w)
        begin
          // Target is loaded one edge later, while the fetch is stalled
          pc_load_next = 1'b1;
          busy_next = 1'b1;
        end
        else if (accept_w)
        begin
          done_next = 1'b1;
        end
      end
      ST_TAKEN:
      begin
        // Second cycle: retire and report the jump
        done_next = 1'b1;
        taken_next = 1'b1;
      end
      default:
      begin
        done_next = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Outputs are plain flip-flops so the fetch sees clean timing
  always @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= ST_IDLE;
      pc_load_o <= 1'b0;
      pc_target_o <= `CFBU_PC_RST;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      taken_o <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      pc_load_o <= pc_load_next;
      pc_target_o <= pc_target_next;
      busy_o <= busy_next;
      done_o <= done_next;
      taken_o <= taken_next;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/cfbu_props.sv ====
// Purpose: Port checks for the branch unit
// Assumes: Condition recomputed from flags
// Notes: Bound by the bench
`default_nettype none
`include "cfbu_consts.vh"
module cfbu_props (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Decoded branch
  input wire logic branch_valid_i,
  input wire logic [`CFBU_SEL_W-1:0] branch_sel_i,
  input wire logic [`CFBU_OFS_W-1:0] branch_ofs_i,
  input wire logic [`CFBU_PC_W-1:0] pc_i,
  // Status flags
  input wire logic flag_neg_i,
  input wire logic flag_ovf_i,
  input wire logic flag_half_i,
  input wire logic flag_xfer_i,
  // Unit outputs
  input wire logic pc_load_o,
  input wire logic [`CFBU_PC_W-1:0] pc_target_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic taken_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic v = flag_neg_i ^ flag_ovf_i;
  wire logic [7:0] c = {~flag_xfer_i, flag_xfer_i, ~flag_half_i, flag_half_i, v, ~v,
    ~flag_neg_i, flag_neg_i};
  wire logic t = c[branch_sel_i];
  wire logic a = branch_valid_i && !busy_o;
  wire logic [`CFBU_PC_W-1:0] nx = pc_i + 16'h1;
  wire logic [`CFBU_PC_W-1:0] x = t ? nx + {{9{branch_ofs_i[6]}}, branch_ofs_i} : nx;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  take_time_a: assert property (a && t |=> pc_load_o && busy_o ##1 done_o && taken_o)
    else $error("taken timing");
  pc_target_a:
    assert property (a |=> pc_target_o == $past(x)) else $error("target");
  fall_thru_a: assert property (a && !t |=> done_o && !busy_o && !taken_o)
    else $error("not taken");
  stall_end_a: assert property (busy_o |=> !busy_o && !pc_load_o) else $error("stall");
  taken_done_a: assert property (taken_o |-> done_o && $past(busy_o)) else $error("taken");
  target_hold_a: assert property (!$past(a) |-> $stable(pc_target_o)) else $error("hold");
  done_src_a: assert property (done_o |-> $past(a) || $past(busy_o)) else $error("done");
  load_src_a: assert property (pc_load_o |-> $past(a) && busy_o) else $error("load");
  cover property (a && t);
  cover property (a && !t);
  cover property (busy_o && branch_valid_i);
endmodule
`default_nettype wire

// ==== testbench/tb_conditional_flag_branch_unit.sv ====
// Purpose: Random branch stream with queued expectations
// Assumes: Bench models the taken-branch stall
// Notes: Requests in a stall cycle are ignored
`default_nettype none
`include "cfbu_consts.vh"
module tb_conditional_flag_branch_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, branch_valid_i = 1'b0, flag_neg_i = 1'b0;
  logic flag_ovf_i = 1'b0, flag_half_i = 1'b0, flag_xfer_i = 1'b0;
  logic [`CFBU_SEL_W-1:0] branch_sel_i = 3'h0;
  logic [`CFBU_OFS_W-1:0] branch_ofs_i = 7'h0;
  logic [`CFBU_PC_W-1:0] pc_i = 16'h0, pc_target_o;
  logic pc_load_o, busy_o, done_o, taken_o, stall = 1'b0, t, q;
  logic [16:0] exp_q[$];
  logic [16:0] e;
  logic [31:0] r;
  logic [7:0] c;
  int n_errors = 0, n_compared = 0, cyc = 0;
  cfbu_branch_unit dut (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .branch_valid_i(branch_valid_i),
    .branch_sel_i(branch_sel_i),
    .branch_ofs_i(branch_ofs_i),
    .pc_i(pc_i),
    .flag_neg_i(flag_neg_i),
    .flag_ovf_i(flag_ovf_i),
    .flag_half_i(flag_half_i),
    .flag_xfer_i(flag_xfer_i),
    .pc_load_o(pc_load_o),
    .pc_target_o(pc_target_o),
    .busy_o(busy_o),
    .done_o(done_o),
    .taken_o(taken_o)
  );
  initial forever #20 ref_clk_i = ~ref_clk_i;
  task test_done;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard
  always @(posedge ref_clk_i)
    if (++cyc > 999)
    begin
      n_errors++;
      test_done;
    end
  always @(negedge ref_clk_i)
    if (done_o === 1'b1)
    begin
      e = exp_q.pop_front();
      n_compared++;
      if ({taken_o, pc_target_o} !== e)
      begin
        n_errors++;
        $display("MISMATCH taken_target exp %h got %h", e, {taken_o, pc_target_o});
      end
    end
  initial
  begin
    void'($urandom(32'h2c28));
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (300)
    begin
      @(posedge ref_clk_i);
      r = $urandom;
      q = r[0] | r[1];
      c = {~r[7], r[7], ~r[6], r[6], r[5] ^ r[4], ~(r[5] ^ r[4]), ~r[5], r[5]};
      t = c[r[10:8]];
      {branch_valid_i, branch_sel_i, branch_ofs_i, pc_i} <= {q, r[10:8], r[17:11], r[31:16]};
      {flag_xfer_i, flag_half_i, flag_neg_i, flag_ovf_i} <= r[7:4];
      // Stall cycle request must vanish
      if (q && !stall)
        exp_q.push_back({t, r[31:16] + (t ? {{9{r[17]}}, r[17:11]} : 16'h0) + 16'h1});
      stall = q && !stall && t;
    end
    // Last request is taken at this edge; stop issuing new ones
    @(posedge ref_clk_i);
    branch_valid_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    if (exp_q.size() != 0)
    begin
      n_errors++;
      $display("MISMATCH pending_results exp %0d got %0d", 0, exp_q.size());
    end
    test_done;
  end
endmodule
bind cfbu_branch_unit cfbu_props u_props (
  .ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i),
  .branch_valid_i(branch_valid_i),
  .branch_sel_i(branch_sel_i),
  .branch_ofs_i(branch_ofs_i),
  .pc_i(pc_i),
  .flag_neg_i(flag_neg_i),
  .flag_ovf_i(flag_ovf_i),
  .flag_half_i(flag_half_i),
  .flag_xfer_i(flag_xfer_i),
  .pc_load_o(pc_load_o),
  .pc_target_o(pc_target_o),
  .busy_o(busy_o),
  .done_o(done_o),
  .taken_o(taken_o)
);
`default_nettype wire
